// ### rtl/rru_defs.svh
`ifndef RRU_DEFS_SVH
`define RRU_DEFS_SVH

// ==========================================
// Widths and reset values
`define RRU_W          8
`define RRU_MSB        7
`define RRU_LSB        0
`define RRU_ACC_RST    8'h00
`define RRU_MEM_RST    8'h00
`define RRU_FLAG_RST   6'h00
// ==========================================
// Rotation step and lowest kept operand bit
`define RRU_STEP       1
`define RRU_KEEP_LSB   1
// ==========================================
// Flag vector positions
`define RRU_F_C        0
`define RRU_F_AC       1
`define RRU_F_Z        2
`define RRU_F_OV       3
`define RRU_F_PD       4
`define RRU_F_TO       5

`endif

// ### rtl/rru_pkg.sv
package rru_pkg;
	typedef enum logic [1:0] {
		RRU_OP_NONE                      = 2'b00,
		RRU_OP_ROTATE_RIGHT_TO_ACC       = 2'b01,
		RRU_OP_ROTATE_RIGHT_CARRY_MEM    = 2'b10,
		RRU_OP_ROTATE_RIGHT_CARRY_TO_ACC = 2'b11
	} rru_op_t;

	// Status flags: to, pd, ov, z, ac, c (c in bit 0)
	typedef logic [5:0] rru_flags_t;

	typedef struct packed {
		rru_op_t    op;
		logic [7:0] operand;
		rru_flags_t flags;
	} rru_req_t;

	typedef struct packed {
		logic [7:0] acc;
		logic       acc_we;
		logic [7:0] mem_wdata;
		logic       mem_we;
		rru_flags_t flags;
		logic       flags_we;
	} rru_res_t;
endpackage

// ### rtl/rru_right_rotate_unit.sv
`timescale 1ns/10ps
`include "rru_defs.svh"

module rru_right_rotate_unit (
	input  wire logic              clock,
	input  wire logic              arst_n,
	input  wire logic              clk_en,
	input  wire rru_pkg::rru_req_t req,
	output rru_pkg::rru_res_t      res
);
	import rru_pkg::*;

	// ==========================================
	// Rotation datapath
	logic [`RRU_MSB:0] plain_rot;
	logic [`RRU_MSB:0] carry_rot;
	logic              carry_in;
	logic              carry_out;

	assign carry_in  = req.flags[`RRU_F_C];
	assign carry_out = req.operand[`RRU_LSB];

	genvar gi;
	generate
		for (gi = `RRU_LSB; gi < `RRU_MSB; gi++) begin : g_shift
			assign plain_rot[gi] = req.operand[gi + `RRU_STEP];
			assign carry_rot[gi] = req.operand[gi + `RRU_STEP];
		end
	endgenerate

	assign plain_rot[`RRU_MSB] = req.operand[`RRU_LSB];
	assign carry_rot[`RRU_MSB] = carry_in;

	// ==========================================
	// Operation decode
	function automatic logic is_acc_op(input rru_op_t op);
		return (op == RRU_OP_ROTATE_RIGHT_TO_ACC) ||
		       (op == RRU_OP_ROTATE_RIGHT_CARRY_TO_ACC);
	endfunction

	function automatic logic is_mem_op(input rru_op_t op);
		return (op == RRU_OP_ROTATE_RIGHT_CARRY_MEM);
	endfunction

	function automatic logic is_carry_op(input rru_op_t op);
		return (op == RRU_OP_ROTATE_RIGHT_CARRY_MEM) ||
		       (op == RRU_OP_ROTATE_RIGHT_CARRY_TO_ACC);
	endfunction

	// ==========================================
	// Registered results
	logic [`RRU_MSB:0] acc_r;
	logic              acc_we_r;
	logic [`RRU_MSB:0] mem_r;
	logic              mem_we_r;
	rru_flags_t        flags_r;
	logic              flags_we_r;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			acc_r <= `RRU_ACC_RST;
		end else if (clk_en) begin
			unique case (req.op)
				RRU_OP_ROTATE_RIGHT_TO_ACC: begin
					acc_r <= plain_rot;
				end
				RRU_OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
					acc_r <= carry_rot;
				end
				RRU_OP_ROTATE_RIGHT_CARRY_MEM,
				RRU_OP_NONE: begin
					acc_r <= acc_r;
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			acc_we_r <= 1'b0;
		end else if (clk_en) begin
			acc_we_r <= is_acc_op(req.op);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			mem_r <= `RRU_MEM_RST;
		end else if (clk_en && is_mem_op(req.op)) begin
			mem_r <= carry_rot;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			mem_we_r <= 1'b0;
		end else if (clk_en) begin
			mem_we_r <= is_mem_op(req.op);
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			flags_r <= `RRU_FLAG_RST;
		end else if (clk_en) begin
			flags_r <= req.flags;
			if (is_carry_op(req.op)) begin
				flags_r[`RRU_F_C] <= carry_out;
			end
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			flags_we_r <= 1'b0;
		end else if (clk_en) begin
			flags_we_r <= is_carry_op(req.op);
		end
	end

	assign res = '{acc: acc_r, acc_we: acc_we_r, mem_wdata: mem_r,
	               mem_we: mem_we_r, flags: flags_r, flags_we: flags_we_r};

	// ==========================================
	// Checks
	property p_plain_acc;
		@(posedge clock) disable iff (!arst_n)
		(clk_en && req.op == RRU_OP_ROTATE_RIGHT_TO_ACC) |=>
			res.acc_we &&
			res.acc == {$past(req.operand[`RRU_LSB]),
			            $past(req.operand[`RRU_MSB:`RRU_KEEP_LSB])};
	endproperty
	a_plain_acc: assert property (p_plain_acc) else $error("plain rotate result wrong");

	property p_plain_no_mem;
		@(posedge clock) disable iff (!arst_n)
		(clk_en && req.op == RRU_OP_ROTATE_RIGHT_TO_ACC) |=> !res.mem_we;
	endproperty
	a_plain_no_mem: assert property (p_plain_no_mem) else $error("plain rotate wrote memory");

	property p_plain_mem_hold;
		@(posedge clock) disable iff (!arst_n)
		(clk_en && req.op == RRU_OP_ROTATE_RIGHT_TO_ACC) |=> $stable(res.mem_wdata);
	endproperty
	a_plain_mem_hold: assert property (p_plain_mem_hold)
		else $error("plain rotate moved memory data");

	property p_carry_mem;
		@(posedge clock) disable iff (!arst_n)
		(clk_en && req.op == RRU_OP_ROTATE_RIGHT_CARRY_MEM) |=>
			res.mem_we && !res.acc_we &&
			res.flags[`RRU_F_C] == $past(req.operand[`RRU_LSB]) &&
			res.mem_wdata == {$past(req.flags[`RRU_F_C]),
			                  $past(req.operand[`RRU_MSB:`RRU_KEEP_LSB])};
	endproperty
	a_carry_mem: assert property (p_carry_mem) else $error("memory carry rotate wrong");

	property p_carry_mem_acc_hold;
		@(posedge clock) disable iff (!arst_n)
		(clk_en && req.op == RRU_OP_ROTATE_RIGHT_CARRY_MEM) |=> $stable(res.acc);
	endproperty
	a_carry_mem_acc_hold: assert property (p_carry_mem_acc_hold)
		else $error("memory carry rotate moved accumulator");

	property p_carry_acc;
		@(posedge clock) disable iff (!arst_n)
		(clk_en && req.op == RRU_OP_ROTATE_RIGHT_CARRY_TO_ACC) |=>
			res.acc_we && !res.mem_we &&
			res.flags[`RRU_F_C] == $past(req.operand[`RRU_LSB]) &&
			res.acc == {$past(req.flags[`RRU_F_C]),
			            $past(req.operand[`RRU_MSB:`RRU_KEEP_LSB])};
	endproperty
	a_carry_acc: assert property (p_carry_acc) else $error("acc carry rotate wrong");

	property p_carry_acc_mem_hold;
		@(posedge clock) disable iff (!arst_n)
		(clk_en && req.op == RRU_OP_ROTATE_RIGHT_CARRY_TO_ACC) |=> $stable(res.mem_wdata);
	endproperty
	a_carry_acc_mem_hold: assert property (p_carry_acc_mem_hold)
		else $error("acc carry rotate moved memory data");

	property p_mem_we_only;
		@(posedge clock) disable iff (!arst_n)
		(clk_en && req.op != RRU_OP_ROTATE_RIGHT_CARRY_MEM) |=> !res.mem_we;
	endproperty
	a_mem_we_only: assert property (p_mem_we_only)
		else $error("memory write without memory rotate");

	property p_flags_kept;
		@(posedge clock) disable iff (!arst_n)
		clk_en |=>
			res.flags[`RRU_F_TO:`RRU_F_AC] ==
			$past(req.flags[`RRU_F_TO:`RRU_F_AC]);
	endproperty
	a_flags_kept: assert property (p_flags_kept) else $error("non-carry flag changed");

	property p_carry_flags_we;
		@(posedge clock) disable iff (!arst_n)
		(clk_en && (req.op == RRU_OP_ROTATE_RIGHT_CARRY_MEM ||
		            req.op == RRU_OP_ROTATE_RIGHT_CARRY_TO_ACC)) |=> res.flags_we;
	endproperty
	a_carry_flags_we: assert property (p_carry_flags_we)
		else $error("carry rotate did not write flags");

	property p_plain_no_flags;
		@(posedge clock) disable iff (!arst_n)
		(clk_en && req.op == RRU_OP_ROTATE_RIGHT_TO_ACC) |=>
			!res.flags_we && res.flags == $past(req.flags);
	endproperty
	a_plain_no_flags: assert property (p_plain_no_flags) else $error("plain rotate hit flags");

	property p_none_quiet;
		@(posedge clock) disable iff (!arst_n)
		(clk_en && req.op == RRU_OP_NONE) |=>
			!res.acc_we && !res.mem_we && !res.flags_we;
	endproperty
	a_none_quiet: assert property (p_none_quiet)
		else $error("idle operation raised a write enable");
endmodule

// ### bench/right_rotate_unit_test.sv
`timescale 1ns/10ps
module right_rotate_unit_test;
	import rru_pkg::*;
	// ====================
	// Stimulus and checks
	logic       clock = 1'b0;
	logic       arst_n = 1'b0;
	logic       clk_en = 1'b1;
	rru_req_t   req = '0;
	rru_res_t   res;
	int         num_errors = 0;
	int         compares = 0;
	always #12.5 clock = ~clock;
	rru_right_rotate_unit dut (.clock(clock), .arst_n(arst_n), .clk_en(clk_en), .req(req),
		.res(res));
	task chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task run(input rru_op_t op, input logic [7:0] d, input rru_flags_t f);
		@(negedge clock);
		req = '{op, d, f};
		@(negedge clock);
		req.op = RRU_OP_NONE;
	endtask
	function automatic logic [7:0] wes();
		return {5'h00, res.acc_we, res.mem_we, res.flags_we};
	endfunction
	task t_plain;
		run(RRU_OP_ROTATE_RIGHT_TO_ACC, 8'h81, 6'h3E);
		chk(res.acc, 8'hC0);
		chk(wes(), 8'h04);
		chk({2'h0, res.flags}, 8'h3E);
		run(RRU_OP_ROTATE_RIGHT_TO_ACC, 8'h01, 6'h01);
		chk(res.acc, 8'h80);
		chk({2'h0, res.flags}, 8'h01);
		$display("plain rotate done");
	endtask
	task t_mem;
		run(RRU_OP_ROTATE_RIGHT_CARRY_MEM, 8'h81, 6'h3E);
		chk(res.mem_wdata, 8'h40);
		chk({2'h0, res.flags}, 8'h3F);
		chk(wes(), 8'h03);
		run(RRU_OP_ROTATE_RIGHT_CARRY_MEM, 8'h02, 6'h01);
		chk(res.mem_wdata, 8'h81);
		chk({2'h0, res.flags}, 8'h00);
		$display("memory rotate done");
	endtask
	task t_acc;
		run(RRU_OP_ROTATE_RIGHT_CARRY_TO_ACC, 8'h02, 6'h21);
		chk(res.acc, 8'h81);
		chk({2'h0, res.flags}, 8'h20);
		chk(wes(), 8'h05);
		run(RRU_OP_ROTATE_RIGHT_CARRY_TO_ACC, 8'h55, 6'h1C);
		chk(res.acc, 8'h2A);
		chk({2'h0, res.flags}, 8'h1D);
		$display("accumulator carry rotate done");
	endtask
	task t_idle;
		run(RRU_OP_NONE, 8'hFF, 6'h00);
		chk(wes(), 8'h00);
		clk_en = 1'b0;
		run(RRU_OP_ROTATE_RIGHT_TO_ACC, 8'hF0, 6'h3F);
		chk(res.acc, 8'h2A);
		chk(wes(), 8'h00);
		chk({2'h0, res.flags}, 8'h00);
		clk_en = 1'b1;
		$display("idle and hold done");
	endtask
	task t_reset;
		run(RRU_OP_ROTATE_RIGHT_CARRY_TO_ACC, 8'h02, 6'h3F);
		arst_n = 1'b0;
		@(negedge clock);
		chk(res.acc, 8'h00);
		chk({2'h0, res.flags}, 8'h00);
		chk(wes(), 8'h00);
		arst_n = 1'b1;
		run(RRU_OP_ROTATE_RIGHT_CARRY_TO_ACC, 8'h03, 6'h00);
		chk(res.acc, 8'h01);
		chk({2'h0, res.flags}, 8'h01);
		$display("mid-run reset done");
	endtask
	task test_done;
		$display("errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge clock);
		chk(wes(), 8'h00);
		arst_n = 1'b1;
		t_plain;
		t_mem;
		t_acc;
		t_idle;
		t_reset;
		test_done;
	end
	initial begin
		#20000;
		num_errors++;
		test_done;
	end
endmodule
